// ===== verilog/cyclic_sense_pkg.sv
// constants shared by the cyclic timers and wake filters
package cyclic_sense_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_WAKE_CTRL  = 7'h06;
  localparam logic [6:0] ADDR_FILTER_SEL = 7'h09;
  localparam logic [6:0] ADDR_TIMER_A    = 7'h0C;
  localparam logic [6:0] ADDR_TIMER_B    = 7'h0D;

  localparam logic [7:0] RST_WAKE_CTRL   = 8'h00;
  localparam logic [7:0] RST_FILTER_SEL  = 8'h00;
  localparam logic [7:0] RST_TIMER       = 8'h00;

  // field positions
  localparam int FLT_A_LSB   = 0;
  localparam int FLT_B_LSB   = 2;
  localparam int FLT_C_LSB   = 4;
  localparam int TMR_PER_LSB = 0;
  localparam int TMR_ON_LSB  = 4;
  localparam int WAKE_EN_A   = 6;
  localparam int WAKE_EN_B   = 7;
  localparam int HS_COUNT    = 4;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
  localparam logic [1:0] FLT_STATIC_LONG  = 2'h1;
  localparam logic [1:0] FLT_CYCLIC_A     = 2'h2;
  localparam logic [1:0] FLT_CYCLIC_B     = 2'h3;

  localparam logic [2:0] ON_OFF_LOW   = 3'h0;
  localparam logic [2:0] ON_LAST_RUN  = 3'h5;
  localparam logic [2:0] ON_OFF_HIGH  = 3'h6;
  localparam logic [2:0] PER_RESERVED = 3'h7;

  localparam logic [2:0] HS_BY_TIMER_A = 3'h2;
  localparam logic [2:0] HS_BY_TIMER_B = 3'h3;

  // ----------------------------------------------------------------
  // timing: all timer arithmetic runs on a 1 us tick
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  localparam logic [6:0] FILTER_SHORT_US = 7'd16;
  localparam logic [6:0] FILTER_LONG_US  = 7'd64;

  // on-time and period in microseconds, indexed by code
  localparam logic [20:0] ON_TIME_US [8] = '{
    21'd0, 21'd100, 21'd300, 21'd1000,
    21'd10000, 21'd20000, 21'd0, 21'd0};
  localparam logic [20:0] PERIOD_US [8] = '{
    21'd10000, 21'd20000, 21'd50000, 21'd100000,
    21'd200000, 21'd1000000, 21'd2000000, 21'd0};

endpackage

// ===== verilog/cyclic_timer.sv
// one cyclic timer: periodic on-time pulse with hold modes
module cyclic_timer
  import cyclic_sense_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // control
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic        holdHigh,
  input  wire logic        restart,
  input  wire logic [20:0] onTicks,
  input  wire logic [20:0] perTicks,
  // status
  output logic             timerOut,
  output logic             onEnd,
  output logic             periodStart
);

  typedef struct packed {
    logic [20:0] cnt;
    logic        out;
    logic        onEnd;
    logic        perStart;
  } timer_s;

  timer_s cur_reg;
  timer_s cur_next;

  always_comb begin
    cur_next = cur_reg;
    cur_next.onEnd = 1'b0;
    cur_next.perStart = 1'b0;
    if (!run) begin
      cur_next.cnt = '0;
      cur_next.out = holdHigh;
    end else if (restart) begin
      cur_next.cnt = '0;
      cur_next.out = 1'b0;
    end else if (tick) begin
      // an on-time longer than the period keeps the output high
      if (cur_reg.cnt == '0) begin
        cur_next.out = 1'b1;
        cur_next.perStart = 1'b1;
      end
      // falling onTicks ticks after the rise gives the full on-time
      if (cur_reg.cnt == onTicks) begin
        cur_next.out = 1'b0;
        cur_next.onEnd = 1'b1;
      end
      if (cur_reg.cnt == perTicks - 21'd1) begin
        cur_next.cnt = '0;
      end else begin
        cur_next.cnt = cur_reg.cnt + 21'd1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign timerOut    = cur_reg.out;
  assign onEnd       = cur_reg.onEnd;
  assign periodStart = cur_reg.perStart;

endmodule

// ===== verilog/cyclic_sense_timers_wake_filter.sv
// cyclic sense timers, wake input filters and their control registers
//
// Operation
// - each of the three wake inputs has its own 2-bit filter code.
// - codes 00 and 01 filter the input statically for 16 us or 64 us.
// - codes 10 and 11 sample the 16 us filtered input at on-time end.
// - reserved register bits always read as zero.
// - on-time codes 001 to 101 give 0.1, 0.3, 1, 10 and 20 ms.
// - on-time 000 stops the timer low, 110 stops it high, 111 reserved.
// - period codes 000 to 110 give 10 ms up to 2 s, 111 is reserved.
// - the second timer has the same layout and encodings as the first.
// - an assigned timer starts by itself once a running code is set.
// - clearing timer-driven switches in restart also clears timers.
// - cyclic wake and cyclic sensing may run together.
// - all four registers reset to zero.
// - a wake-enable bit per timer makes its cycle a wake source.
// - switch codes 010 and 011 follow the first or second timer.
module cyclic_sense_timers_wake_filter
  import cyclic_sense_pkg::*;
#(
  parameter logic [11:0] TICK_DIV = 12'(TICK_CYCLES)
)
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // register port
  input  wire logic [6:0]            regAddr,
  input  wire logic [7:0]            regWrData,
  input  wire logic                  regWrEn,
  input  wire logic                  regRdEn,
  output logic      [7:0]            regRdData,
  // switch configuration and device state
  input  wire logic [3*HS_COUNT-1:0] hsCfg,
  input  wire logic                  restartState,
  // wake pins
  input  wire logic                  wakeInputA,
  input  wire logic                  wakeInputB,
  input  wire logic                  wakeInputC,
  // results
  output logic      [2:0]            wakeLevel,
  output logic      [HS_COUNT-1:0]   hsTimerDrive,
  output logic      [1:0]            timerWakeEvent
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic usesCode(input logic [3*HS_COUNT-1:0] cfg,
                                    input logic [2:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < HS_COUNT; i++) begin
      if (cfg[3*i +: 3] == code) hit = 1'b1;
    end
    return hit;
  endfunction

  function automatic logic isRunCode(input logic [2:0] onCode,
                                     input logic [2:0] perCode);
    return onCode != ON_OFF_LOW && onCode <= ON_LAST_RUN
           && perCode != PER_RESERVED;
  endfunction

  typedef struct packed {
    logic [11:0]     prescale;
    logic            tick;
    logic [1:0]      wakeEn;
    logic [5:0]      fltSel;
    logic [2:0]      onA;
    logic [2:0]      perA;
    logic [2:0]      onB;
    logic [2:0]      perB;
    logic [7:0]      rdData;
    logic [2:0]      syncFirst;
    logic [2:0]      syncSecond;
    logic [2:0][6:0] fltCnt;
    logic [2:0]      fltLvl;
    logic [2:0]      wake;
    logic [HS_COUNT-1:0] hsDrive;
    logic [1:0]      wakeEvt;
    logic            cycPrev;
  } core_s;

  core_s cur_reg;
  core_s cur_next;

  logic usesA;
  logic usesB;
  logic runA;
  logic runB;
  logic restartA;
  logic restartB;
  logic outA;
  logic outB;
  logic onEndA;
  logic onEndB;
  logic perStartA;
  logic perStartB;

  assign usesA = usesCode(hsCfg, HS_BY_TIMER_A);
  assign usesB = usesCode(hsCfg, HS_BY_TIMER_B);
  // a timer needs a user before it runs
  assign runA = isRunCode(cur_reg.onA, cur_reg.perA)
                && (usesA || cur_reg.wakeEn[0]);
  assign runB = isRunCode(cur_reg.onB, cur_reg.perB)
                && (usesB || cur_reg.wakeEn[1]);
  assign restartA = regWrEn && regAddr == ADDR_TIMER_A;
  assign restartB = regWrEn && regAddr == ADDR_TIMER_B;

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  cyclic_timer timerA (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .tick        (cur_reg.tick),
    .run         (runA),
    .holdHigh    (cur_reg.onA == ON_OFF_HIGH),
    .restart     (restartA),
    .onTicks     (ON_TIME_US[cur_reg.onA]),
    .perTicks    (PERIOD_US[cur_reg.perA]),
    .timerOut    (outA),
    .onEnd       (onEndA),
    .periodStart (perStartA)
  );

  cyclic_timer timerB (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .tick        (cur_reg.tick),
    .run         (runB),
    .holdHigh    (cur_reg.onB == ON_OFF_HIGH),
    .restart     (restartB),
    .onTicks     (ON_TIME_US[cur_reg.onB]),
    .perTicks    (PERIOD_US[cur_reg.perB]),
    .timerOut    (outB),
    .onEnd       (onEndB),
    .periodStart (perStartB)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] code;
    logic [6:0] limit;
    code  = 2'h0;
    limit = FILTER_SHORT_US;
    cur_next = cur_reg;

    // 1 us tick
    cur_next.tick = 1'b0;
    if (cur_reg.prescale >= TICK_DIV - 12'd1) begin
      cur_next.prescale = '0;
      cur_next.tick = 1'b1;
    end else begin
      cur_next.prescale = cur_reg.prescale + 12'd1;
    end

    // register writes
    if (regWrEn) begin
      case (regAddr)
        ADDR_WAKE_CTRL: begin
          cur_next.wakeEn = {regWrData[WAKE_EN_B], regWrData[WAKE_EN_A]};
        end
        ADDR_FILTER_SEL: cur_next.fltSel = regWrData[5:0];
        ADDR_TIMER_A: begin
          cur_next.onA  = regWrData[TMR_ON_LSB +: 3];
          cur_next.perA = regWrData[TMR_PER_LSB +: 3];
        end
        ADDR_TIMER_B: begin
          cur_next.onB  = regWrData[TMR_ON_LSB +: 3];
          cur_next.perB = regWrData[TMR_PER_LSB +: 3];
        end
        default: ;
      endcase
    end

    // switches dropped off the timers in restart: stop stale sensing
    cur_next.cycPrev = usesA || usesB;
    if (restartState && cur_reg.cycPrev && !(usesA || usesB)) begin
      cur_next.onA  = ON_OFF_LOW;
      cur_next.perA = '0;
      cur_next.onB  = ON_OFF_LOW;
      cur_next.perB = '0;
    end

    // register reads show the live fields, zeros elsewhere
    if (regRdEn) begin
      case (regAddr)
        ADDR_WAKE_CTRL:  cur_next.rdData = {cur_reg.wakeEn, 6'h00};
        ADDR_FILTER_SEL: cur_next.rdData = {2'h0, cur_reg.fltSel};
        ADDR_TIMER_A: begin
          cur_next.rdData = {1'b0, cur_reg.onA, 1'b0, cur_reg.perA};
        end
        ADDR_TIMER_B: begin
          cur_next.rdData = {1'b0, cur_reg.onB, 1'b0, cur_reg.perB};
        end
        default: cur_next.rdData = 8'h00;
      endcase
    end

    // wake inputs: synchronise, filter, then sample or pass
    cur_next.syncFirst  = {wakeInputC, wakeInputB, wakeInputA};
    cur_next.syncSecond = cur_reg.syncFirst;
    for (int i = 0; i < 3; i++) begin
      code  = cur_reg.fltSel[2*i +: 2];
      limit = (code == FLT_STATIC_LONG) ? FILTER_LONG_US
                                        : FILTER_SHORT_US;
      if (cur_reg.syncSecond[i] == cur_reg.fltLvl[i]) begin
        cur_next.fltCnt[i] = '0;
      end else if (cur_reg.tick) begin
        if (cur_reg.fltCnt[i] + 7'd1 >= limit) begin
          cur_next.fltLvl[i] = cur_reg.syncSecond[i];
          cur_next.fltCnt[i] = '0;
        end else begin
          cur_next.fltCnt[i] = cur_reg.fltCnt[i] + 7'd1;
        end
      end
      case (code)
        FLT_CYCLIC_A: if (onEndA) cur_next.wake[i] = cur_reg.fltLvl[i];
        FLT_CYCLIC_B: if (onEndB) cur_next.wake[i] = cur_reg.fltLvl[i];
        default: cur_next.wake[i] = cur_reg.fltLvl[i];
      endcase
    end

    // switch drive and cyclic wake run side by side
    for (int i = 0; i < HS_COUNT; i++) begin
      if (hsCfg[3*i +: 3] == HS_BY_TIMER_A) begin
        cur_next.hsDrive[i] = outA;
      end else if (hsCfg[3*i +: 3] == HS_BY_TIMER_B) begin
        cur_next.hsDrive[i] = outB;
      end else begin
        cur_next.hsDrive[i] = 1'b0;
      end
    end
    cur_next.wakeEvt = {perStartB && cur_reg.wakeEn[1],
                        perStartA && cur_reg.wakeEn[0]};
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_reg        <= '0;
      cur_reg.wakeEn <= RST_WAKE_CTRL[7:6];
      cur_reg.fltSel <= RST_FILTER_SEL[5:0];
      cur_reg.onA    <= RST_TIMER[6:4];
      cur_reg.perA   <= RST_TIMER[2:0];
      cur_reg.onB    <= RST_TIMER[6:4];
      cur_reg.perB   <= RST_TIMER[2:0];
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign regRdData      = cur_reg.rdData;
  assign wakeLevel      = cur_reg.wake;
  assign hsTimerDrive   = cur_reg.hsDrive;
  assign timerWakeEvent = cur_reg.wakeEvt;

endmodule

// ===== testbench/wake_contact_model.sv
// wake contact seen through a timer-driven high-side switch
module wake_contact_model #(
  parameter int SETTLE = 2
)
(
  // switch and contact
  input  wire logic hsDrive,
  input  wire logic contactClosed,
  input  wire logic clk,
  // wake pin
  output logic      wakePin
);
  timeunit 1ns;
  timeprecision 1ps;
  // the pin is pulled down whenever the switch does not feed the contact
  logic [7:0] lagReg = '0;
  always @(posedge clk) lagReg <= {lagReg[6:0], hsDrive & contactClosed};
  assign wakePin = lagReg[SETTLE];
endmodule

// ===== testbench/cyclic_sense_checker.sv
// assertions on the cyclic timer and wake filter ports
module cyclic_sense_checker
  import cyclic_sense_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic [6:0]            regAddr,
  input wire logic [7:0]            regWrData,
  input wire logic                  regWrEn,
  input wire logic                  regRdEn,
  input wire logic [7:0]            regRdData,
  input wire logic [3*HS_COUNT-1:0] hsCfg,
  input wire logic                  restartState,
  input wire logic [HS_COUNT-1:0]   hsTimerDrive,
  input wire logic [1:0]            timerWakeEvent
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // write shadows
  // ------
  // restart may clear timer a behind our back, so its shadow is distrusted
  logic [5:0] fltReg;
  logic [2:0] onAReg;
  logic       onAOkReg;
  logic       wakeEnAReg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fltReg     <= '0;
      onAReg     <= '0;
      onAOkReg   <= 1'b1;
      wakeEnAReg <= 1'b0;
    end else begin
      if (regWrEn && regAddr == ADDR_FILTER_SEL) fltReg <= regWrData[5:0];
      if (regWrEn && regAddr == ADDR_TIMER_A) onAReg <= regWrData[6:4];
      if (regWrEn && regAddr == ADDR_TIMER_A) onAOkReg <= 1'b1;
      if (restartState) onAOkReg <= 1'b0;
      if (regWrEn && regAddr == ADDR_WAKE_CTRL) wakeEnAReg <= regWrData[6];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_filter_read_back: assert property (
    regRdEn && regAddr == ADDR_FILTER_SEL
    |=> regRdData == {2'h0, $past(fltReg)})
    else $error("filter select read back wrong");
  a_timer_rsvd_zero: assert property (
    regRdEn && (regAddr == ADDR_TIMER_A || regAddr == ADDR_TIMER_B)
    |=> !regRdData[7] && !regRdData[3]) else $error("reserved timer bit set");
  a_drive_needs_code: assert property (
    hsCfg[2:0] != HS_BY_TIMER_A && hsCfg[2:0] != HS_BY_TIMER_B
    |=> !hsTimerDrive[0]) else $error("switch driven without timer code");
  a_stop_low_hold: assert property (
    (onAOkReg && onAReg == ON_OFF_LOW && hsCfg[2:0] != HS_BY_TIMER_B)[*4]
    |-> !hsTimerDrive[0]) else $error("stopped timer drives high");
  a_stop_high_hold: assert property (
    (onAOkReg && onAReg == ON_OFF_HIGH && hsCfg[2:0] == HS_BY_TIMER_A
    && !restartState)[*4] |-> hsTimerDrive[0]) else $error("hold high lost");
  a_wake_a_spaced: assert property (
    timerWakeEvent[0] |=> (!timerWakeEvent[0])[*8])
    else $error("timer a wake event too long");
  a_wake_b_single: assert property (
    timerWakeEvent[1] |=> !timerWakeEvent[1])
    else $error("timer b wake event too long");
  a_wake_a_enabled: assert property (
    timerWakeEvent[0]
    |-> wakeEnAReg || $past(wakeEnAReg) || $past(wakeEnAReg, 2))
    else $error("wake event while disabled");
  c_wake_evt: cover property (timerWakeEvent[0]);
  c_drive_rise: cover property ($rose(hsTimerDrive[0]));
  c_timer_read: cover property (regRdEn && regAddr == ADDR_TIMER_B);
endmodule
bind cyclic_sense_timers_wake_filter cyclic_sense_checker cyclic_sense_checker_inst (
  .clk, .sys_rst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
  .hsCfg, .restartState, .hsTimerDrive, .timerWakeEvent);

// ===== testbench/cyclic_sense_timers_wake_filter_tb_top.sv
// testbench for the cyclic timers and wake filters
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH %0t: got %h want %h", $time, a, b); end end
module cyclic_sense_timers_wake_filter_tb_top
  import cyclic_sense_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // short tick keeps a 10 ms period at 20000 clocks
  localparam int TD = 2;
  logic        clk          = 1'b0;
  logic        sys_rst      = 1'b1;
  logic [6:0]  regAddr      = '0;
  logic [7:0]  regWrData    = '0;
  logic        regWrEn      = 1'b0;
  logic        regRdEn      = 1'b0;
  logic [11:0] hsCfg        = '0;
  logic        restartState = 1'b0;
  logic        wakeInputB   = 1'b0;
  logic        wakeInputC   = 1'b0;
  logic        wakeInputA;
  logic [7:0]  regRdData;
  logic [2:0]  wakeLevel;
  logic [3:0]  hsTimerDrive;
  logic [1:0]  timerWakeEvent;
  int          miscompares  = 0;
  int          check_count  = 0;
  int          evCnt        = 0;
  int          evCntB       = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (timerWakeEvent[0] === 1'b1) evCnt++;
    if (timerWakeEvent[1] === 1'b1) evCntB++;
  end
  cyclic_sense_timers_wake_filter #(.TICK_DIV(12'(TD)))
    cyclic_sense_timers_wake_filter_inst (.clk, .sys_rst, .regAddr,
    .regWrData, .regWrEn, .regRdEn, .regRdData, .hsCfg, .restartState,
    .wakeInputA, .wakeInputB, .wakeInputC, .wakeLevel,
    .hsTimerDrive, .timerWakeEvent);
  wake_contact_model wake_contact_model_inst (.clk, .contactClosed(1'b1),
    .hsDrive(hsTimerDrive[0]), .wakePin(wakeInputA));
  // ------
  // tasks
  // ------
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    step(1);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    step(1);
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    step(1);
    regAddr = a;
    regRdEn = 1'b1;
    step(1);
    regRdEn = 1'b0;
    d = regRdData;
  endtask
  task automatic wait_drive(input logic lvl, output int n);
    for (n = 0; hsTimerDrive[0] !== lvl; n++) begin
      if (n > 40000) begin
        miscompares++;
        give_verdict();
      end
      step(1);
    end
  endtask
  task automatic t_regs();
    logic [7:0] d;
    logic [6:0] adr [5] = '{ADDR_WAKE_CTRL, ADDR_FILTER_SEL, ADDR_TIMER_A,
                            ADDR_TIMER_B, 7'h01};
    logic [7:0] exp [5] = '{8'hC0, 8'h3F, 8'h77, 8'h77, 8'h00};
    foreach (adr[i]) begin
      rd(adr[i], d);
      `CHK(d, 8'h00)
      wr(adr[i], 8'hFF);
      rd(adr[i], d);
      `CHK(d, exp[i])
      wr(adr[i], 8'h00);
    end
  endtask
  task automatic t_cycle();
    int hi;
    int lo;
    hsCfg = 12'h002;
    wr(ADDR_WAKE_CTRL, 8'h40);
    wr(ADDR_FILTER_SEL, 8'h02);
    evCnt = 0;
    wr(ADDR_TIMER_A, 8'h10);
    wait_drive(1'b1, hi);
    wait_drive(1'b0, hi);
    `CHK(hi, 100 * TD)
    step(100);
    `CHK(wakeLevel[0], 1'b1)
    wait_drive(1'b1, lo);
    // the 100 idle cycles above belong to the low phase as well
    `CHK(hi + lo + 100, 10000 * TD)
    step(3);
    `CHK(evCnt, 2)
  endtask
  task automatic t_static();
    for (int c = 0; c < 2; c++) begin
      // inputs b and c get opposite codes to show separate selections
      wr(ADDR_FILTER_SEL, 8'((c << 2) | ((1 - c) << 4)));
      wakeInputB = 1'b1;
      wakeInputC = 1'b1;
      step(40 * TD);
      `CHK(wakeLevel[1], 1'(c == 0))
      `CHK(wakeLevel[2], 1'(c == 1))
      wakeInputB = 1'b0;
      wakeInputC = 1'b0;
      step(80 * TD);
    end
  endtask
  task automatic t_hold();
    hsCfg = 12'h018;
    wr(ADDR_TIMER_A, 8'h60);
    wr(ADDR_TIMER_B, 8'h60);
    step(4);
    `CHK(hsTimerDrive, 4'h2)
    hsCfg = 12'h01A;
    wr(ADDR_TIMER_B, 8'h00);
    step(4);
    `CHK(hsTimerDrive, 4'h1)
  endtask
  task automatic t_restart();
    logic [7:0] d;
    wr(ADDR_WAKE_CTRL, 8'h80);
    evCntB = 0;
    wr(ADDR_TIMER_B, 8'h13);
    restartState = 1'b1;
    step(2);
    hsCfg = 12'h000;
    step(2);
    restartState = 1'b0;
    rd(ADDR_TIMER_A, d);
    `CHK(d, 8'h00)
    rd(ADDR_TIMER_B, d);
    `CHK(d, 8'h00)
    `CHK(evCntB, 1)
  endtask
  initial begin
    step(10);
    sys_rst = 1'b0;
    t_regs();
    t_cycle();
    t_static();
    t_hold();
    t_restart();
    give_verdict();
  end
endmodule
